// ===== lpcs_regs.svh
// register indices, field positions, reset values and interval counts
`ifndef LPCS_REGS_SVH
`define LPCS_REGS_SVH

// register word indices; byte address is four times the index
`define LPCS_IDX_CTRL        10'h06e
`define LPCS_IDX_GAIN        10'h07a
`define LPCS_IDX_BANDGAP     10'h07c
`define LPCS_IDX_TERM_A      10'h07e
`define LPCS_IDX_TERM_B      10'h07f
`define LPCS_IDX_MODE        10'h090
`define LPCS_IDX_STATUS      10'h091

// lowpower_cal_control fields
`define LPCS_CTRL_SLEEP_HI   7
`define LPCS_CTRL_SLEEP_LO   5
`define LPCS_CTRL_WAKE_HI    4
`define LPCS_CTRL_WAKE_LO    3
`define LPCS_CTRL_TRIGSEL    1
`define LPCS_CTRL_ENABLE     0
`define LPCS_CTRL_RESET      8'h88

// mode register fields
`define LPCS_MODE_BGCAL      0
`define LPCS_MODE_SRCSEL     1
`define LPCS_MODE_SOFTTRIG   2
`define LPCS_MODE_RESET      8'h04

// band-gap trim field top bit; field is bits 3:0
`define LPCS_BG_HI           3

// trim reset value before the fuse load
`define LPCS_TRIM_RESET      8'h00

// interval counts in device clock cycles
`define LPCS_CNT_W           41
`define LPCS_CYC_MIN         41'd1152

`endif

// ===== lpcs_pkg.sv
// types shared by the calibration scheduler and trim bank
package lpcs_pkg;

    typedef enum logic [1:0] {
        LPCS_IDLE   = 2'b00,
        LPCS_SLEEP  = 2'b01,
        LPCS_SETTLE = 2'b10,
        LPCS_CAL    = 2'b11
    } lpcs_state_e;

    typedef logic [1:0] lpcs_trim_idx_t;

endpackage

// ===== lpcs_fuse_rom.sv
// factory fuse memory holding the four trim values, registered read
`timescale 1ns/10ps
`default_nettype none

module lpcs_fuse_rom #(
    parameter logic [7:0] FUSE_GAIN    = 8'h00, // arbitrary factory value
    parameter logic [7:0] FUSE_BANDGAP = 8'h00, // arbitrary factory value
    parameter logic [7:0] FUSE_TERM_A  = 8'h00, // arbitrary factory value
    parameter logic [7:0] FUSE_TERM_B  = 8'h00  // arbitrary factory value
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   rd_en,
    input  wire lpcs_pkg::lpcs_trim_idx_t addr,
    output logic [7:0]                  rdata
);

    logic [7:0] word;

    // fuse contents selected by address
    assign word = (addr == 2'h0) ? FUSE_GAIN :
                  (addr == 2'h1) ? FUSE_BANDGAP :
                  (addr == 2'h2) ? FUSE_TERM_A : FUSE_TERM_B;

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
        end else if (ce && rd_en) begin
            rdata <= word;
        end
    end

endmodule
`default_nettype wire

// ===== lpcs_interval_timer.sv
// interval counter that flags the last cycle of a programmed span
`timescale 1ns/10ps
`default_nettype none
`include "lpcs_regs.svh"

module lpcs_interval_timer (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    ce,
    input  wire logic                    clear,
    input  wire logic [`LPCS_CNT_W-1:0]  limit,
    output logic                         expired
);

    logic [`LPCS_CNT_W-1:0] count_reg;

    // last cycle of a span of limit cycles
    assign expired = (count_reg == limit - `LPCS_CNT_W'd1);

    // count from zero, hold at the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (ce) begin
            if (clear) begin
                count_reg <= '0;
            end else if (!expired) begin
                count_reg <= count_reg + `LPCS_CNT_W'd1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== lpcs_cal_sched.sv
// low-power calibration scheduler and fuse-loaded trim bank, apb slave
// Notes on behaviour
// RULE1: sleep code 0..7 sets sleep span, 1,152 up to 1,099,511,627,904 cycles.
// RULE2: sleep span counts only when enabled and trigger-sleep is off.
// RULE3: software keeps sleep code at 4 or above; reset value is 4.
// RULE4: wake code 0..3 sets settle span before calibration while enabled.
// RULE5: software avoids wake code 0; reset value is 1.
// RULE6: trigger-sleep off: sleep ends when the sleep span runs out.
// RULE7: trigger-sleep on: asleep while trigger high, wakes while trigger low.
// RULE8: enable resets to 0; works only with background calibration mode.
// RULE9: software writes reserved bits only with their reset value.
// RULE10: one gain trim drives all cores; full scale set elsewhere.
// RULE11: band-gap trim is a 4-bit read-write field in bits 3:0.
// RULE12: trims load from fuses after reset, then read and write freely.
// RULE13: channel a and b termination trims are separate 8-bit registers.
// RULE14: trigger comes from software bit when select is 0, else pin.
// RULE15: counters restart when disabled or trigger-sleep select changes.
`timescale 1ns/10ps
`default_nettype none
`include "lpcs_regs.svh"

module lpcs_cal_sched #(
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_1 = 41'd4194432,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_2 = 41'd33554560,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_3 = 41'd268435584,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_4 = 41'd2147483776,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_5 = 41'd17179869312,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_6 = 41'd137438953600,
    parameter logic [`LPCS_CNT_W-1:0] SLEEP_CYC_7 = 41'd1099511627904,
    parameter logic [`LPCS_CNT_W-1:0] WAKE_CYC_1  = 41'd33554560,
    parameter logic [`LPCS_CNT_W-1:0] WAKE_CYC_2  = 41'd268435584,
    parameter logic [`LPCS_CNT_W-1:0] WAKE_CYC_3  = 41'd2147483776,
    parameter logic [7:0]             FUSE_GAIN    = 8'h00, // arbitrary
    parameter logic [7:0]             FUSE_BANDGAP = 8'h00, // arbitrary
    parameter logic [7:0]             FUSE_TERM_A  = 8'h00, // arbitrary
    parameter logic [7:0]             FUSE_TERM_B  = 8'h00  // arbitrary
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cal_trigger_pin,
    input  wire logic        cal_done,
    output logic             core_sleep,
    output logic             cal_start,
    output logic [7:0]       gain_trim_out,
    output logic [3:0]       bandgap_trim_out,
    output logic [7:0]       term_trim_a_out,
    output logic [7:0]       term_trim_b_out
);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0]            ctrl_reg;
    logic [7:0]            mode_reg;
    logic [7:0]            trim_reg [4];
    logic [31:0]           prdata_reg;
    logic                  trig_meta_reg;
    logic                  trig_sync_reg;
    logic                  trigsel_prev_reg;
    logic                  cal_start_reg;
    logic                  loading_reg;
    logic                  busy_reg;
    logic [2:0]            ld_cnt_reg;
    logic                  ld_pend_reg;
    lpcs_pkg::lpcs_trim_idx_t ld_idx_reg;
    lpcs_pkg::lpcs_state_e state_reg;
    lpcs_pkg::lpcs_state_e state_next;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [9:0]  word_idx;
    logic        aligned;
    logic        hit_ctrl, hit_gain, hit_bg, hit_ta, hit_tb, hit_mode, hit_stat;
    logic        hit;
    logic        acc_done;
    logic        wr_en;
    logic [31:0] rd_word;
    logic [7:0]  status_byte;

    // word index and per-register hits
    assign word_idx = paddr[11:2];
    assign aligned  = (paddr[1:0] == 2'b00);
    assign hit_ctrl = aligned && (word_idx == `LPCS_IDX_CTRL);
    assign hit_gain = aligned && (word_idx == `LPCS_IDX_GAIN);
    assign hit_bg   = aligned && (word_idx == `LPCS_IDX_BANDGAP);
    assign hit_ta   = aligned && (word_idx == `LPCS_IDX_TERM_A);
    assign hit_tb   = aligned && (word_idx == `LPCS_IDX_TERM_B);
    assign hit_mode = aligned && (word_idx == `LPCS_IDX_MODE);
    assign hit_stat = aligned && (word_idx == `LPCS_IDX_STATUS);
    assign hit      = hit_ctrl | hit_gain | hit_bg | hit_ta | hit_tb | hit_mode | hit_stat;

    // wait states while fuses load, one cycle after, and while ce is low
    assign pready   = !loading_reg && !busy_reg && ce;
    assign acc_done = psel && penable && pready && ce;
    assign wr_en    = acc_done && pwrite && hit;
    assign pslverr  = psel && penable && pready && !hit;
    assign prdata   = prdata_reg;

    // read mux, bits 31:8 and unmapped words read zero; reserved bits read back as stored
    assign status_byte = {4'h0, state_reg, core_sleep, loading_reg};
    assign rd_word = hit_ctrl ? {24'h0, ctrl_reg} :
                     hit_gain ? {24'h0, trim_reg[0]} :
                     hit_bg   ? {24'h0, trim_reg[1]} :
                     hit_ta   ? {24'h0, trim_reg[2]} :
                     hit_tb   ? {24'h0, trim_reg[3]} :
                     hit_mode ? {24'h0, mode_reg} :
                     hit_stat ? {24'h0, status_byte} : 32'h0;

    // read data captured every selected cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (ce && psel) begin
            prdata_reg <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // fuse load after reset
    // ------------------------------------------------------------
    logic       ld_issue;
    logic [7:0] fuse_rdata;

    assign ld_issue = loading_reg && (ld_cnt_reg != 3'h4);

    lpcs_fuse_rom #(
        .FUSE_GAIN    (FUSE_GAIN),
        .FUSE_BANDGAP (FUSE_BANDGAP),
        .FUSE_TERM_A  (FUSE_TERM_A),
        .FUSE_TERM_B  (FUSE_TERM_B)
    ) u_fuse (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .rd_en   (ld_issue),
        .addr    (ld_cnt_reg[1:0]),
        .rdata   (fuse_rdata)
    );

    // sequence four fuse reads, then open the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loading_reg <= 1'b1;
            busy_reg    <= 1'b1;
            ld_cnt_reg  <= 3'h0;
            ld_pend_reg <= 1'b0;
            ld_idx_reg  <= 2'h0;
        end else if (ce) begin
            busy_reg    <= loading_reg;
            ld_pend_reg <= ld_issue;
            ld_idx_reg  <= ld_cnt_reg[1:0];
            if (ld_issue) begin
                ld_cnt_reg <= ld_cnt_reg + 3'h1;
            end
            if (ld_pend_reg && ld_idx_reg == 2'h3) begin
                loading_reg <= 1'b0;
            end
        end
    end

    // trim bank: fuse values first, software afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                trim_reg[i] <= `LPCS_TRIM_RESET;
            end
        end else if (ce) begin
            if (ld_pend_reg) begin
                trim_reg[ld_idx_reg] <= fuse_rdata; // RULE12
            end else if (wr_en && hit_gain) begin
                trim_reg[0] <= pwdata[7:0]; // RULE10
            end else if (wr_en && hit_bg) begin
                trim_reg[1] <= pwdata[7:0]; // RULE11
            end else if (wr_en && hit_ta) begin
                trim_reg[2] <= pwdata[7:0]; // RULE13
            end else if (wr_en && hit_tb) begin
                trim_reg[3] <= pwdata[7:0]; // RULE13
            end
        end
    end

    // trims drive the analog side from their registers
    assign gain_trim_out    = trim_reg[0]; // RULE10
    assign bandgap_trim_out = trim_reg[1][`LPCS_BG_HI:0]; // RULE11
    assign term_trim_a_out  = trim_reg[2]; // RULE13
    assign term_trim_b_out  = trim_reg[3]; // RULE13

    // control and mode registers, reserved bits stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `LPCS_CTRL_RESET; // RULE3 RULE5 RULE8
            mode_reg <= `LPCS_MODE_RESET;
        end else if (ce) begin
            if (wr_en && hit_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (wr_en && hit_mode) begin
                mode_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // trigger path
    // ------------------------------------------------------------
    logic cal_trigger;
    logic trig_mode;
    logic active;
    logic restart;

    // pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
        end else if (ce) begin
            trig_meta_reg <= cal_trigger_pin;
            trig_sync_reg <= trig_meta_reg;
        end
    end

    // source select, enable gating and restart
    assign cal_trigger = mode_reg[`LPCS_MODE_SRCSEL] ? trig_sync_reg
                                                     : mode_reg[`LPCS_MODE_SOFTTRIG]; // RULE14
    assign trig_mode = ctrl_reg[`LPCS_CTRL_TRIGSEL];
    assign active    = ctrl_reg[`LPCS_CTRL_ENABLE] && mode_reg[`LPCS_MODE_BGCAL]; // RULE8
    assign restart   = !active || (trig_mode != trigsel_prev_reg); // RULE15

    // ------------------------------------------------------------
    // scheduler
    // ------------------------------------------------------------
    logic [`LPCS_CNT_W-1:0] sleep_limit;
    logic [`LPCS_CNT_W-1:0] wake_limit;
    logic [`LPCS_CNT_W-1:0] span_limit;
    logic                   span_expired;
    logic                   span_clear;

    // sleep span per code
    function automatic logic [`LPCS_CNT_W-1:0] sleep_cycles(input logic [2:0] code);
        unique case (code)
            3'h0: sleep_cycles = `LPCS_CYC_MIN;
            3'h1: sleep_cycles = SLEEP_CYC_1;
            3'h2: sleep_cycles = SLEEP_CYC_2;
            3'h3: sleep_cycles = SLEEP_CYC_3;
            3'h4: sleep_cycles = SLEEP_CYC_4;
            3'h5: sleep_cycles = SLEEP_CYC_5;
            3'h6: sleep_cycles = SLEEP_CYC_6;
            3'h7: sleep_cycles = SLEEP_CYC_7;
        endcase
    endfunction

    // settle span per code
    function automatic logic [`LPCS_CNT_W-1:0] wake_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: wake_cycles = `LPCS_CYC_MIN;
            2'h1: wake_cycles = WAKE_CYC_1;
            2'h2: wake_cycles = WAKE_CYC_2;
            2'h3: wake_cycles = WAKE_CYC_3;
        endcase
    endfunction

    // one counter serves sleep and settle spans
    assign sleep_limit = sleep_cycles(ctrl_reg[`LPCS_CTRL_SLEEP_HI:`LPCS_CTRL_SLEEP_LO]); // RULE1
    assign wake_limit  = wake_cycles(ctrl_reg[`LPCS_CTRL_WAKE_HI:`LPCS_CTRL_WAKE_LO]); // RULE4
    assign span_limit  = (state_reg == lpcs_pkg::LPCS_SETTLE) ? wake_limit : sleep_limit;
    assign span_clear  = restart || (state_next != state_reg); // RULE15

    lpcs_interval_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .clear   (span_clear),
        .limit   (span_limit),
        .expired (span_expired)
    );

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lpcs_pkg::LPCS_IDLE: begin
                state_next = lpcs_pkg::LPCS_SLEEP;
            end
            lpcs_pkg::LPCS_SLEEP: begin
                if (trig_mode) begin
                    if (!cal_trigger) begin
                        state_next = lpcs_pkg::LPCS_SETTLE; // RULE7
                    end
                end else if (span_expired) begin
                    state_next = lpcs_pkg::LPCS_SETTLE; // RULE2 RULE6
                end
            end
            lpcs_pkg::LPCS_SETTLE: begin
                if (span_expired) begin
                    state_next = lpcs_pkg::LPCS_CAL; // RULE4
                end
            end
            lpcs_pkg::LPCS_CAL: begin
                if (cal_done) begin
                    state_next = lpcs_pkg::LPCS_SLEEP;
                end
            end
        endcase
        if (restart) begin
            state_next = lpcs_pkg::LPCS_IDLE; // RULE15
        end
    end

    // state, select history and calibration start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg        <= lpcs_pkg::LPCS_IDLE;
            trigsel_prev_reg <= 1'b0;
            cal_start_reg    <= 1'b0;
        end else if (ce) begin
            state_reg        <= state_next;
            trigsel_prev_reg <= trig_mode;
            cal_start_reg    <= (state_next == lpcs_pkg::LPCS_CAL) && (state_reg != lpcs_pkg::LPCS_CAL);
        end
    end

    assign core_sleep = (state_reg == lpcs_pkg::LPCS_SLEEP);
    assign cal_start  = cal_start_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_settle_done;
        ce && state_reg == lpcs_pkg::LPCS_SETTLE && span_expired && !restart;
    endsequence

    property p_off_idle;
        (ce && !active) |=> state_reg == lpcs_pkg::LPCS_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("scheduler ran while disabled"); // RULE8

    property p_sel_restart;
        (ce && trig_mode != trigsel_prev_reg) |=> state_reg == lpcs_pkg::LPCS_IDLE;
    endproperty
    a_sel_restart: assert property (p_sel_restart) else $error("no restart on select change"); // RULE15

    property p_trig_wake;
        (ce && core_sleep && trig_mode && !cal_trigger && !restart) |=> state_reg == lpcs_pkg::LPCS_SETTLE;
    endproperty
    a_trig_wake: assert property (p_trig_wake) else $error("low trigger did not wake core"); // RULE7

    property p_trig_hold;
        (ce && core_sleep && trig_mode && cal_trigger && !restart) |=> core_sleep;
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("core woke with trigger high"); // RULE7

    property p_auto_end;
        (ce && core_sleep && !trig_mode && !restart) |=> (core_sleep == !$past(span_expired));
    endproperty
    a_auto_end: assert property (p_auto_end) else $error("sleep span end wrong"); // RULE6

    property p_settle_start;
        s_settle_done |=> cal_start && state_reg == lpcs_pkg::LPCS_CAL ##1 !cal_start;
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("calibration start missing"); // RULE4

    property p_bg_write;
        (wr_en && hit_bg && !ld_pend_reg) |=> bandgap_trim_out == $past(pwdata[3:0]);
    endproperty
    a_bg_write: assert property (p_bg_write) else $error("band-gap trim not written"); // RULE11

    property p_term_own;
        (wr_en && hit_ta) |=> $stable(term_trim_b_out);
    endproperty
    a_term_own: assert property (p_term_own) else $error("channel a write touched channel b"); // RULE13

    property p_soft_src;
        !mode_reg[`LPCS_MODE_SRCSEL] |-> cal_trigger == mode_reg[`LPCS_MODE_SOFTTRIG];
    endproperty
    a_soft_src: assert property (p_soft_src) else $error("pin used as trigger source"); // RULE14

    property p_fuse_loaded;
        $fell(loading_reg) |-> gain_trim_out == FUSE_GAIN && term_trim_b_out == FUSE_TERM_B;
    endproperty
    a_fuse_loaded: assert property (p_fuse_loaded) else $error("fuse values not loaded"); // RULE12

endmodule
`default_nettype wire

// ===== lpcs_dummy_end.sv
`default_nettype wire

// ===== test_lpcs_cal_sched.sv
// self-checking bench for the calibration scheduler and trim bank
`timescale 1ns/10ps
`default_nettype none
`include "lpcs_regs.svh"

module test_lpcs_cal_sched;
    localparam int         SL [8] = '{1152, 20, 27, 34, 41, 48, 55, 62};
    localparam int         WK [4] = '{1152, 21, 29, 37};
    localparam logic [7:0] FU [4] = '{8'h5a, 8'h3c, 8'ha7, 8'h61}; // arbitrary fuse values
    localparam logic [9:0] IX [4] = '{`LPCS_IDX_GAIN, `LPCS_IDX_BANDGAP, `LPCS_IDX_TERM_A, `LPCS_IDX_TERM_B};
    logic        pclk, presetn, psel, penable, pwrite, pin, tog, err, ce, pin_lvl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, core_sleep, cal_start;
    logic [7:0]  g_o, a_o, b_o;
    logic [3:0]  bg_o;
    int          n_fail, check_count, k, m;

    // design with shortened interval counts
    lpcs_cal_sched #(
        .SLEEP_CYC_1(41'(SL[1])), .SLEEP_CYC_2(41'(SL[2])), .SLEEP_CYC_3(41'(SL[3])),
        .SLEEP_CYC_4(41'(SL[4])), .SLEEP_CYC_5(41'(SL[5])), .SLEEP_CYC_6(41'(SL[6])),
        .SLEEP_CYC_7(41'(SL[7])), .WAKE_CYC_1(41'(WK[1])), .WAKE_CYC_2(41'(WK[2])),
        .WAKE_CYC_3(41'(WK[3])), .FUSE_GAIN(FU[0]), .FUSE_BANDGAP(FU[1]),
        .FUSE_TERM_A(FU[2]), .FUSE_TERM_B(FU[3])
    ) DUT (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cal_trigger_pin(pin), .cal_done(1'b1), .core_sleep(core_sleep),
        .cal_start(cal_start), .gain_trim_out(g_o), .bandgap_trim_out(bg_o),
        .term_trim_a_out(a_o), .term_trim_b_out(b_o)
    );

    // clock, 10 ns period
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // pin follows pin_lvl, or toggles when the software source must ignore it
    always @(posedge pclk) begin
        pin <= tog ? ~pin : pin_lvl;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // settle length: cycles from core wake to the calibration start pulse
    task automatic wake_len();
        m = 0;
        while (core_sleep === 1'b1 && m < 200) begin @(negedge pclk); m++; end
        m = 0;
        while (cal_start !== 1'b1 && m < 3000) begin @(negedge pclk); m++; end
    endtask

    task automatic measure(input int sc, input int wc);
        k = 0;
        while (core_sleep !== 1'b1 && k < 10) begin @(negedge pclk); k++; end
        k = 0;
        while (core_sleep === 1'b1 && k < 3000) begin @(negedge pclk); k++; end
        wake_len();
        chk(k, SL[sc]);
        chk(m, WK[wc]);
    endtask

    // core_sleep must reach the given level, then hold it over a span
    task automatic hold_chk(input logic lvl);
        k = 0;
        while (core_sleep !== lvl && k < 60) begin @(negedge pclk); k++; end
        k = 0;
        repeat (90) begin @(negedge pclk); k += (core_sleep !== lvl); end
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [7:0] v [4];
        int         wc;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pin_lvl = 1'b0; tog = 1'b0; ce = 1'b1;
        n_fail = 0; check_count = 0;
        void'($urandom(32'h892e));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // fuse load, then random overwrite and readback
        for (int i = 0; i < 4; i++) begin apb(IX[i], 1'b0, 32'h0); chk(rd, {24'h0, FU[i]}); end
        chk({g_o, bg_o, a_o, b_o}, {FU[0], FU[1][3:0], FU[2], FU[3]});
        for (int i = 0; i < 4; i++) begin
            v[i] = 8'($urandom);
            if (i == 1) v[i][7:4] = 4'h0;
            apb(IX[i], 1'b1, {24'h0, v[i]});
        end
        for (int i = 0; i < 4; i++) begin apb(IX[i], 1'b0, 32'h0); chk(rd, {24'h0, v[i]}); end
        chk({g_o, bg_o, a_o, b_o}, {v[0], v[1][3:0], v[2], v[3]});
        // clock enable low stalls a write until it comes back
        ce <= 1'b0;
        fork
            apb(IX[0], 1'b1, 32'hc3);
            begin repeat (6) @(posedge pclk); ce <= 1'b1; end
        join
        apb(IX[0], 1'b0, 32'h0);
        chk(rd, 32'hc3);
        apb(`LPCS_IDX_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h88);
        apb(10'h3ff, 1'b1, 32'hff);
        chk(err, 1'b1);
        apb(10'h3ff, 1'b0, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // enabled without background mode: no sleep
        apb(`LPCS_IDX_CTRL, 1'b1, 32'h89);
        hold_chk(1'b0);
        chk(k, 0);
        apb(`LPCS_IDX_MODE, 1'b1, 32'h01);
        for (int sc = 0; sc < 8; sc++) begin
            wc = (sc == 0) ? 0 : 1 + sc % 3;
            apb(`LPCS_IDX_CTRL, 1'b1, 32'h0);
            apb(`LPCS_IDX_CTRL, 1'b1, {24'h0, sc[2:0], wc[1:0], 3'b001});
            measure(sc, wc);
        end
        // trigger-sleep, software source high, pin toggling
        apb(`LPCS_IDX_CTRL, 1'b1, 32'h0);
        apb(`LPCS_IDX_MODE, 1'b1, 32'h05);
        tog <= 1'b1;
        apb(`LPCS_IDX_CTRL, 1'b1, 32'h2b);
        hold_chk(1'b1);
        chk(k, 0);
        apb(`LPCS_IDX_MODE, 1'b1, 32'h01);
        wake_len();
        chk(m, WK[1]);
        // pin source, software bit ignored
        tog <= 1'b0;
        pin_lvl <= 1'b1;
        apb(`LPCS_IDX_MODE, 1'b1, 32'h03);
        hold_chk(1'b1);
        chk(k, 0);
        pin_lvl <= 1'b0;
        wake_len();
        chk(m, WK[1]);
        wrap_up();
    end
endmodule

`default_nettype wire
